// >>> auxmx_host.sv
// host model driving the register port
`timescale 1ns/1ps
module auxmx_host (
  input wire logic mclk,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr = 8'h00,
  output logic [7:0] reg_wdata = 8'h00,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0
);
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    d = reg_rdata;
  endtask
endmodule

// >>> auxmx_pkg.sv
// constants for the auxiliary channel multiplexer selection block
package auxmx_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int SEL_W = 5;
  localparam logic [7:0] OFS_SLOT1_NEG = 8'heb;
  localparam logic [7:0] OFS_SLOT1_POS = 8'hec;
  localparam logic [7:0] OFS_SLOT2_NEG = 8'hed;
  localparam logic [7:0] OFS_SLOT2_POS = 8'hee;
  localparam logic [7:0] OFS_FAST_NEG = 8'hf3;
  localparam logic [7:0] OFS_FAST_POS = 8'hf4;
  localparam logic [7:0] OFS_FAST_CTRL = 8'hf5;
  localparam logic [4:0] SEL_RESET = 5'h00;
  localparam logic [4:0] SEL_GROUND = 5'h00;
  localparam int FC_CONT_BIT = 0;
  localparam int FC_AUX_BIT = 1;
  localparam logic [1:0] FC_RESET = 2'h0;
  localparam logic [7:0] RDATA_ZERO = 8'h00;
  localparam int CLK_PERIOD_NS = 25;
  localparam int FAST_START_US = 2;
  localparam int FAST_START_CYC = (FAST_START_US * 1000) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  typedef enum logic [1:0] {
    AUXMX_SLOW = 2'b00,
    AUXMX_START = 2'b01,
    AUXMX_FAST = 2'b11
  } auxmx_state_e;
endpackage

// >>> auxmx_select.sv
// register bank and input selection for the auxiliary conversion channel
// What this block does
// - slow mode alternates two slots round robin
// - each slot has own positive/negative 5-bit code
// - fast mode converts one single differential pair
// - fast pair from fast select registers only
// - selection frozen while continuous fast runs
// - slot1 negative select at 0xeb, resets zero
// - slot1 positive select at 0xec, resets zero
// - slot2 negative select at 0xed, resets zero
// - slot2 positive select at 0xee, resets zero
// - fast negative select at 0xf3, resets zero
// - fast positive select at 0xf4, resets zero
// - fast conversion starts after enable edge or trigger
`timescale 1ns/1ps
module auxmx_select #(
  parameter int START_CYC = auxmx_pkg::FAST_START_CYC
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [auxmx_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [auxmx_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [auxmx_pkg::DATA_W-1:0] reg_rdata,
  input wire logic conv_trigger,
  input wire logic conv_done,
  output logic [auxmx_pkg::SEL_W-1:0] pos_sel,
  output logic [auxmx_pkg::SEL_W-1:0] neg_sel,
  output logic [(1<<auxmx_pkg::SEL_W)-1:0] pos_onehot,
  output logic [(1<<auxmx_pkg::SEL_W)-1:0] neg_onehot,
  output logic slot_is_two,
  output logic fast_mode,
  output logic fast_start,
  output logic sel_locked
);
  localparam int NIN = 1 << auxmx_pkg::SEL_W;
  localparam logic [auxmx_pkg::CNT_W-1:0] START_LOAD = START_CYC[auxmx_pkg::CNT_W-1:0];
  localparam logic [auxmx_pkg::CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [auxmx_pkg::CNT_W-1:0] CNT_ZERO = 8'h00;

  logic [4:0] s1n_reg;
  logic [4:0] s1p_reg;
  logic [4:0] s2n_reg;
  logic [4:0] s2p_reg;
  logic [4:0] fn_reg;
  logic [4:0] fp_reg;
  logic [1:0] fctrl_reg;
  logic cont_prev_reg;
  logic slot_reg;
  logic [4:0] pos_reg;
  logic [4:0] neg_reg;
  logic [4:0] fpos_hold_reg;
  logic [4:0] fneg_hold_reg;
  logic [7:0] rdata_reg;
  logic start_reg;
  logic [auxmx_pkg::CNT_W-1:0] cnt_reg;
  logic [auxmx_pkg::CNT_W-1:0] cnt_next;
  auxmx_pkg::auxmx_state_e state_reg;
  auxmx_pkg::auxmx_state_e state_next;
  logic lock_reg;
  logic fast_reg;

  // address decode
  wire wr_s1n = reg_wr && (reg_addr == auxmx_pkg::OFS_SLOT1_NEG);
  wire wr_s1p = reg_wr && (reg_addr == auxmx_pkg::OFS_SLOT1_POS);
  wire wr_s2n = reg_wr && (reg_addr == auxmx_pkg::OFS_SLOT2_NEG);
  wire wr_s2p = reg_wr && (reg_addr == auxmx_pkg::OFS_SLOT2_POS);
  wire wr_fn = reg_wr && (reg_addr == auxmx_pkg::OFS_FAST_NEG);
  wire wr_fp = reg_wr && (reg_addr == auxmx_pkg::OFS_FAST_POS);
  wire wr_fc = reg_wr && (reg_addr == auxmx_pkg::OFS_FAST_CTRL);
  wire [4:0] wsel = reg_wdata[auxmx_pkg::SEL_W-1:0];

  // fast control bits
  wire cont_en = fctrl_reg[auxmx_pkg::FC_CONT_BIT];
  wire aux_fast_en = fctrl_reg[auxmx_pkg::FC_AUX_BIT];
  wire cont_rise = cont_en && !cont_prev_reg;
  wire start_req = aux_fast_en && (cont_rise || conv_trigger);
  wire in_slow = (state_reg == auxmx_pkg::AUXMX_SLOW);

  // read mux, narrow codes in the low bits, upper bits read zero
  logic [7:0] rd_mux;
  always_comb
  begin
    rd_mux = auxmx_pkg::RDATA_ZERO;
    case (reg_addr)
      auxmx_pkg::OFS_SLOT1_NEG: rd_mux = {3'h0, s1n_reg};
      auxmx_pkg::OFS_SLOT1_POS: rd_mux = {3'h0, s1p_reg};
      auxmx_pkg::OFS_SLOT2_NEG: rd_mux = {3'h0, s2n_reg};
      auxmx_pkg::OFS_SLOT2_POS: rd_mux = {3'h0, s2p_reg};
      auxmx_pkg::OFS_FAST_NEG: rd_mux = {3'h0, fn_reg};
      auxmx_pkg::OFS_FAST_POS: rd_mux = {3'h0, fp_reg};
      auxmx_pkg::OFS_FAST_CTRL: rd_mux = {6'h00, fctrl_reg};
      default: rd_mux = auxmx_pkg::RDATA_ZERO;
    endcase
  end

  // mode sequencer
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      auxmx_pkg::AUXMX_SLOW:
      begin
        if (start_req)
        begin
          state_next = auxmx_pkg::AUXMX_START;
          cnt_next = START_LOAD;
        end
      end
      auxmx_pkg::AUXMX_START:
      begin
        if (cnt_reg <= CNT_ONE)
        begin
          state_next = auxmx_pkg::AUXMX_FAST;
          cnt_next = CNT_ZERO;
        end
        else
        begin
          cnt_next = cnt_reg - CNT_ONE;
        end
      end
      auxmx_pkg::AUXMX_FAST:
      begin
        // a single triggered conversion, or a series just disabled, ends here
        if (conv_done && !(cont_en && aux_fast_en))
          state_next = auxmx_pkg::AUXMX_SLOW;
      end
      default:
      begin
        state_next = auxmx_pkg::AUXMX_SLOW;
        cnt_next = CNT_ZERO;
      end
    endcase
  end

  // next values; a write hits one register, unmapped offsets change nothing
  wire [4:0] s1n_next = wr_s1n ? wsel : s1n_reg;
  wire [4:0] s1p_next = wr_s1p ? wsel : s1p_reg;
  wire [4:0] s2n_next = wr_s2n ? wsel : s2n_reg;
  wire [4:0] s2p_next = wr_s2p ? wsel : s2p_reg;
  wire [4:0] fn_next = wr_fn ? wsel : fn_reg;
  wire [4:0] fp_next = wr_fp ? wsel : fp_reg;
  wire [1:0] wfc = reg_wdata[auxmx_pkg::FC_AUX_BIT:auxmx_pkg::FC_CONT_BIT];
  wire [1:0] fctrl_next = wr_fc ? wfc : fctrl_reg;
  wire [7:0] rdata_next = reg_rd ? rd_mux : auxmx_pkg::RDATA_ZERO;

  // status comes from next values, so the flip-flops agree with the state
  wire fast_next = (state_next == auxmx_pkg::AUXMX_FAST);
  wire start_next = (state_reg == auxmx_pkg::AUXMX_START) &&
                    (state_next == auxmx_pkg::AUXMX_FAST);
  // a running continuous fast series freezes the pair it started with
  wire lock_next = (state_next != auxmx_pkg::AUXMX_SLOW) &&
                   fctrl_next[auxmx_pkg::FC_CONT_BIT] &&
                   fctrl_next[auxmx_pkg::FC_AUX_BIT];
  // slot moves only on slow conversions; a fast burst resumes the round
  // where it paused, so neither slot is skipped
  wire slot_next = (in_slow && conv_done) ? !slot_reg : slot_reg;
  wire [4:0] fpos_hold_next = lock_reg ? fpos_hold_reg : fp_reg;
  wire [4:0] fneg_hold_next = lock_reg ? fneg_hold_reg : fn_reg;

  // applied pair: the active slot in the slow state, else the fast pair (start and fast states)
  wire [4:0] fast_pos = lock_reg ? fpos_hold_reg : fp_reg;
  wire [4:0] fast_neg = lock_reg ? fneg_hold_reg : fn_reg;
  wire [4:0] slow_pos = slot_reg ? s2p_reg : s1p_reg;
  wire [4:0] slow_neg = slot_reg ? s2n_reg : s1n_reg;
  wire [4:0] pos_next = in_slow ? slow_pos : fast_pos;
  wire [4:0] neg_next = in_slow ? slow_neg : fast_neg;

  // register file
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      s1n_reg <= auxmx_pkg::SEL_RESET;
    else
      s1n_reg <= s1n_next;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      s1p_reg <= auxmx_pkg::SEL_RESET;
    else
      s1p_reg <= s1p_next;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      s2n_reg <= auxmx_pkg::SEL_RESET;
    else
      s2n_reg <= s2n_next;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      s2p_reg <= auxmx_pkg::SEL_RESET;
    else
      s2p_reg <= s2p_next;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      fn_reg <= auxmx_pkg::SEL_RESET;
    else
      fn_reg <= fn_next;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      fp_reg <= auxmx_pkg::SEL_RESET;
    else
      fp_reg <= fp_next;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      fctrl_reg <= auxmx_pkg::FC_RESET;
    else
      fctrl_reg <= fctrl_next;
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      rdata_reg <= auxmx_pkg::RDATA_ZERO;
    else
      rdata_reg <= rdata_next;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= auxmx_pkg::AUXMX_SLOW;
      cnt_reg <= CNT_ZERO;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // edge detect starts low, so leaving reset never fakes a rising edge
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      cont_prev_reg <= 1'b0;
    else
      cont_prev_reg <= cont_en;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      start_reg <= 1'b0;
    else
      start_reg <= start_next;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      fast_reg <= 1'b0;
    else
      fast_reg <= fast_next;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      lock_reg <= 1'b0;
    else
      lock_reg <= lock_next;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      slot_reg <= 1'b0;
    else
      slot_reg <= slot_next;
  end

  // hold copy follows the registers until the series locks
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      fpos_hold_reg <= auxmx_pkg::SEL_RESET;
    else
      fpos_hold_reg <= fpos_hold_next;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      fneg_hold_reg <= auxmx_pkg::SEL_RESET;
    else
      fneg_hold_reg <= fneg_hold_next;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      pos_reg <= auxmx_pkg::SEL_GROUND;
    else
      pos_reg <= pos_next;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      neg_reg <= auxmx_pkg::SEL_GROUND;
    else
      neg_reg <= neg_next;
  end

  // one-hot bits load from the next code, so they stay aligned with the codes
  // bit 0 of each one-hot vector is ground, bit n is input n
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi = gi + 1)
    begin : g_dec
      localparam logic [4:0] CODE = 5'(gi);
      localparam logic HOT_RESET = (CODE == auxmx_pkg::SEL_GROUND);
      logic pos_hot_reg;
      logic neg_hot_reg;
      always_ff @(posedge mclk or negedge rstn)
      begin
        if (!rstn)
        begin
          pos_hot_reg <= HOT_RESET;
          neg_hot_reg <= HOT_RESET;
        end
        else
        begin
          pos_hot_reg <= (pos_next == CODE);
          neg_hot_reg <= (neg_next == CODE);
        end
      end
      assign pos_onehot[gi] = pos_hot_reg;
      assign neg_onehot[gi] = neg_hot_reg;
    end
  endgenerate

  assign reg_rdata = rdata_reg;
  assign pos_sel = pos_reg;
  assign neg_sel = neg_reg;
  assign slot_is_two = slot_reg;
  assign fast_mode = fast_reg;
  assign fast_start = start_reg;
  assign sel_locked = lock_reg;
endmodule

// >>> auxmx_select_asserts.sv
// assertion checker for the auxiliary mux selection block
`timescale 1ns/1ps
module auxmx_select_asserts (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic conv_done,
  input wire logic [4:0] pos_sel,
  input wire logic [4:0] neg_sel,
  input wire logic [31:0] pos_onehot,
  input wire logic [31:0] neg_onehot,
  input wire logic slot_is_two,
  input wire logic fast_mode,
  input wire logic fast_start,
  input wire logic sel_locked
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  pos_dec_a: assert property (pos_onehot == 32'h1 << pos_sel)
    else $error("pos decode wrong");
  neg_dec_a: assert property (neg_onehot == 32'h1 << neg_sel)
    else $error("neg decode wrong");
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside slot");
  rd_pad_a: assert property (reg_rdata[7:5] == 3'h0)
    else $error("upper bits set");
  slot_cause_a: assert property ($changed(slot_is_two) |-> $past(conv_done))
    else $error("slot moved without done");
  lock_hold_a: assert property ($past(sel_locked, 2) && $past(sel_locked) && sel_locked
    |-> $stable(pos_sel) && $stable(neg_sel)) else $error("locked select moved");
  start_edge_a: assert property (fast_start |-> $rose(fast_mode))
    else $error("start pulse misplaced");
  fast_end_a: assert property (conv_done && fast_mode && !sel_locked |=> !fast_mode)
    else $error("fast did not end");
  fast_slot_a: assert property (fast_mode |=> $stable(slot_is_two))
    else $error("slot moved in fast");
  cover property (fast_start);
  cover property (sel_locked);
  cover property ($rose(slot_is_two));
endmodule
bind auxmx_select auxmx_select_asserts chk_u (
  .mclk(mclk),
  .rstn(rstn),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .conv_done(conv_done),
  .pos_sel(pos_sel),
  .neg_sel(neg_sel),
  .pos_onehot(pos_onehot),
  .neg_onehot(neg_onehot),
  .slot_is_two(slot_is_two),
  .fast_mode(fast_mode),
  .fast_start(fast_start),
  .sel_locked(sel_locked)
);

// >>> auxmx_select_tb.sv
// self-checking bench for the auxiliary mux selection block
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module aux_channel_mux_select_tb;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic conv_trigger = 1'b0;
  logic conv_done = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic reg_wr, reg_rd, slot_is_two, fast_mode, fast_start, sel_locked;
  logic [4:0] pos_sel, neg_sel;
  logic [31:0] pos_onehot, neg_onehot;
  logic [31:0] seed = 32'ha56a;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  int m[6];
  int slot_q[$] = '{0, 1};
  initial forever #12.5 mclk = ~mclk;
  auxmx_host host_u (.mclk(mclk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
  // short start delay keeps the run brief
  auxmx_select #(.START_CYC(3)) dut_u (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .conv_trigger(conv_trigger), .conv_done(conv_done), .pos_sel(pos_sel),
    .neg_sel(neg_sel), .pos_onehot(pos_onehot), .neg_onehot(neg_onehot),
    .slot_is_two(slot_is_two), .fast_mode(fast_mode), .fast_start(fast_start),
    .sel_locked(sel_locked));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] ofs(input int i);
    return (i < 4) ? 8'heb + 8'(i) : 8'hef + 8'(i);
  endfunction
  task automatic pulse(input bit t, input int w);
    @(posedge mclk);
    if (t) conv_trigger <= 1'b1;
    else conv_done <= 1'b1;
    @(posedge mclk);
    conv_trigger <= 1'b0;
    conv_done <= 1'b0;
    repeat (w) @(posedge mclk);
  endtask
  task automatic chk_sel(input int p, input int n);
    `CHK(pos_sel, 5'(p))
    `CHK(neg_sel, 5'(n))
    `CHK(pos_onehot, 32'h1 << p)
    `CHK(neg_onehot, 32'h1 << n)
  endtask
  task automatic slow_done();
    pulse(0, 2);
    slot_q.push_back(slot_q.pop_front());
    `CHK(slot_is_two, 1'(slot_q[0]))
    chk_sel(m[2 * slot_q[0] + 1], m[2 * slot_q[0]]);
  endtask
  task automatic wfs();
    for (int k = 0; k < 20 && fast_start !== 1'b1; k++) @(posedge mclk);
    `CHK(fast_start, 1'b1)
  endtask
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
    begin
      $display("SIMULATION PASSED");
    end
    else
    begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_total++;
      end_sim();
    end
  end
  initial
  begin
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      host_u.rd(ofs(i), rv);
      `CHK(rv, 8'h00)
      rv = 8'(xs());
      m[i] = int'(rv[4:0]);
      host_u.wr(ofs(i), rv);
    end
    host_u.rd(8'hef, rv);
    `CHK(rv, 8'h00)
    for (int i = 0; i < 6; i++)
    begin
      host_u.rd(ofs(i), rv);
      `CHK(rv, 8'(m[i]))
    end
    chk_sel(m[1], m[0]);
    $display("register test done");
    slow_done();
    `CHK(slot_is_two, 1'b1)
    chk_sel(m[3], m[2]);
    slow_done();
    chk_sel(m[1], m[0]);
    $display("slot test done");
    host_u.wr(8'hf5, 8'h03);
    wfs();
    chk_sel(m[5], m[4]);
    `CHK(sel_locked, 1'b1)
    m[5] = m[5] ^ 1;
    // stored now, applied only once the series is disabled
    host_u.wr(8'hf4, 8'(m[5]));
    chk_sel(m[5] ^ 1, m[4]);
    host_u.rd(8'hf4, rv);
    `CHK(rv, 8'(m[5]))
    pulse(0, 2);
    `CHK(fast_mode, 1'b1)
    host_u.wr(8'hf5, 8'h00);
    pulse(0, 2);
    `CHK(fast_mode, 1'b0)
    chk_sel(m[1], m[0]);
    $display("continuous test done");
    host_u.wr(8'hf5, 8'h02);
    pulse(1, 0);
    wfs();
    chk_sel(m[5], m[4]);
    `CHK(sel_locked, 1'b0)
    pulse(0, 2);
    `CHK(fast_mode, 1'b0)
    $display("trigger test done");
    end_sim();
  end
endmodule
